// file: verilog/msgbuf_pkg.sv
// Purpose: shared constants and types of the CAN message buffer manager
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   frame buffers are 13 bytes, packed as byte arrays
package msgbuf_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int FRAME_BYTES = 13;
   localparam int NUM_TXBUF   = 3;
   localparam int LOCAL_PRIORITY_FIELD_W      = 8;

   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_OPTION  = 12'h000;
   localparam logic [11:0] OFS_MODE    = 12'h004;
   localparam logic [11:0] OFS_RXFLAG  = 12'h008;
   localparam logic [11:0] OFS_RXMASK  = 12'h00c;
   localparam logic [11:0] OFS_TXFLAG  = 12'h010;
   localparam logic [11:0] OFS_TXCTRL  = 12'h014;
   localparam logic [11:0] OFS_TXPRIO0 = 12'h018;
   localparam logic [11:0] OFS_RXBUF   = 12'h040;
   localparam logic [11:0] OFS_TXBUF0  = 12'h080;
   localparam logic [11:0] OFS_TXSTEP  = 12'h040;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE   = 0;
   localparam int BIT_LOOPBACK = 0;
   localparam int BIT_RXF      = 0;
   localparam int BIT_OVR      = 1;
   localparam int BIT_ABORT_ACK_FLAG    = 4;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] RST_TXE  = 3'h7;
   localparam logic [7:0] RST_LOCAL_PRIORITY_FIELD = 8'h00;

   typedef logic [FRAME_BYTES*8-1:0] frame_t;

   typedef struct packed {
      logic       done;
      logic       ok;
      logic       accepted;
      logic       own;
      logic       lost_arb;
      frame_t     data;
   } rx_event_s;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_BUSY = 2'b01
   } tx_state_e;

endpackage

// file: verilog/msgbuf_mgr.sv
// Purpose: receive FIFO and transmit scheduling of a CAN controller
// Assumes: protocol engine delivers whole frames and takes whole frames
// Notes:   bit timing, filter internals and error counters live elsewhere
`timescale 1ns/1ps

// Notes on behaviour
// - tx pin low means dominant, high recessive; one serial out, one in
// - exactly three independent transmit buffers
// - two-stage rx fifo: hidden background, cpu-visible foreground
// - each rx buffer holds 13 bytes
// - rx full set only for a good accepted frame in foreground
// - every frame overwrites background, whatever the filter says, except while both rx buffers are full
// - copy to foreground only if rx full clear, then set flag, irq
// - new frame may land in background right after inter-frame space
// - own frame in normal mode: background only, no copy, irq or ack
// - loop-back treats own frames like any received frame
// - lost arbitration: winning frame handled as normal reception
// - both buffers full and another accepted frame: drop it, flag overrun
// - transmission continues while both rx buffers are full
// - tx buffer is 13 bytes plus an 8-bit local priority
// - successful send sets tx empty and requests tx interrupt
// - lowest priority value among scheduled buffers goes first
// - selection re-runs at every arbitration, retries included
// - abort request never stops a frame already on the bus
// - granted abort sets abort ack and tx empty, raises tx interrupt
// - one option bit enables or disables the whole controller
// - flags cleared by writing one; stay set while cause persists
module msgbuf_mgr
   import msgbuf_pkg::*;
#(
   parameter int NBUF = NUM_TXBUF
) (
   input  wire logic            CLK,
   input  wire logic            RESET_N,
   input  wire logic            PSEL,
   input  wire logic            PENABLE,
   input  wire logic            PWRITE,
   input  wire logic [11:0]     PADDR,
   input  wire logic [31:0]     PWDATA,
   input  wire logic [3:0]      PSTRB,
   output logic      [31:0]     PRDATA,
   output logic                 PREADY,
   output logic                 PSLVERR,
   input  wire logic            CAN_RX,
   output logic                 CAN_TX,
   input  wire logic            ENG_TXD,
   output logic                 ENG_RXD,
   input  wire rx_event_s       RX_EVT,
   input  wire logic            ENG_ACK_REQ,
   output logic                 ENG_ACK_EN,
   input  wire logic            ARB_START,
   output logic                 TX_REQ,
   output frame_t               TX_FRAME,
   input  wire logic            TX_DONE,
   input  wire logic            TX_ERR,
   output logic                 RX_IRQ,
   output logic                 TX_IRQ,
   output logic                 ERR_IRQ,
   output logic                 ENABLED
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic               enable_r;
   logic               loop_r;
   logic               rxf_r, ovr_r;
   logic [1:0]         rxie_r;
   logic [NBUF-1:0]    txe_r, abort_request_bit_r, abort_ack_flag_r, txie_r;
   logic [LOCAL_PRIORITY_FIELD_W-1:0]  local_priority_field_r [NBUF];
   logic [7:0]         txbuf_r [NBUF][FRAME_BYTES];
   frame_t             bg_r, fg_r;
   logic               bg_full_r;
   tx_state_e          tx_st_r;
   logic [1:0]         cur_r;
   logic               rx_s1_r, rx_s2_r;
   logic [31:0]        rdata_r;

   // ---------------------------------------------------------------
   // pin side
   // ---------------------------------------------------------------
   // rx pin comes from another domain: two flops before use
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= CAN_RX;
         rx_s2_r <= rx_s1_r;
      end
   end

   assign CAN_TX  = enable_r ? ENG_TXD : 1'b1;
   assign ENG_RXD = loop_r ? ENG_TXD : rx_s2_r;
   assign ENABLED = enable_r;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   wire        wr_en   = PSEL & PENABLE & PWRITE;
   wire        rd_en   = PSEL & PENABLE & ~PWRITE;
   wire [11:0] word_a  = {PADDR[11:2], 2'b00};
   wire        hit_opt = word_a == OFS_OPTION;
   wire        hit_md  = word_a == OFS_MODE;
   wire        hit_rf  = word_a == OFS_RXFLAG;
   wire        hit_rm  = word_a == OFS_RXMASK;
   wire        hit_tf  = word_a == OFS_TXFLAG;
   wire        hit_tc  = word_a == OFS_TXCTRL;
   wire        hit_pr  = word_a >= OFS_TXPRIO0 &&
                         word_a < OFS_TXPRIO0 + 12'(4*NBUF);
   wire        hit_rb  = word_a >= OFS_RXBUF && word_a < OFS_RXBUF + 12'h010;
   wire        hit_tb  = word_a >= OFS_TXBUF0 &&
                         word_a < OFS_TXBUF0 + 12'(NBUF) * OFS_TXSTEP;
   wire [1:0]  pr_idx  = 2'((word_a - OFS_TXPRIO0) >> 2);
   wire [11:0] tb_off  = word_a - OFS_TXBUF0;
   wire [1:0]  tb_idx  = 2'(tb_off >> 6);
   wire [3:0]  tb_word = 4'(tb_off[5:2]);
   wire [1:0]  rb_word = 2'((word_a - OFS_RXBUF) >> 2);
   wire        mapped  = hit_opt | hit_md | hit_rf | hit_rm | hit_tf | hit_tc |
                         hit_pr | hit_rb | (hit_tb && tb_word < 4'd4);

   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;

   // ---------------------------------------------------------------
   // transmit selection
   // ---------------------------------------------------------------
   // lowest value wins
   // strict compare keeps lower index on ties
   logic [1:0]        best;
   logic              any_sched;
   logic [LOCAL_PRIORITY_FIELD_W-1:0] best_p;
   always_comb begin
      best      = 2'd0;
      best_p    = '1;
      any_sched = 1'b0;
      for (int i = 0; i < NBUF; i++) begin
         if (!txe_r[i] && (!any_sched || local_priority_field_r[i] < best_p)) begin
            best      = 2'(i);
            best_p    = local_priority_field_r[i];
            any_sched = 1'b1;
         end
      end
   end

   always_comb begin
      for (int b = 0; b < FRAME_BYTES; b++) begin
         TX_FRAME[b*8 +: 8] = txbuf_r[cur_r][b];
      end
   end
   assign TX_REQ = enable_r & (tx_st_r == TX_BUSY);

   // ---------------------------------------------------------------
   // receive qualification
   // ---------------------------------------------------------------
   // own frame in normal mode never reaches the foreground
   wire own_blk  = RX_EVT.own & ~RX_EVT.lost_arb & ~loop_r;
   wire good_acc = enable_r & RX_EVT.done & RX_EVT.ok & RX_EVT.accepted & ~own_blk;
   wire rxf_clr  = wr_en & hit_rf & PSTRB[0] & PWDATA[BIT_RXF];
   wire fg_free  = ~rxf_r | rxf_clr;
   // copy only into a free foreground
   wire do_copy  = good_acc & fg_free;
   // both stages full: drop and flag
   wire do_ovr   = good_acc & ~fg_free & bg_full_r;
   wire bg_pend  = bg_full_r & fg_free;

   // no acknowledge for own frames outside loop-back
   assign ENG_ACK_EN = enable_r & ENG_ACK_REQ & ~own_blk;

   // ---------------------------------------------------------------
   // receive fifo
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         bg_r      <= '0;
         fg_r      <= '0;
         bg_full_r <= 1'b0;
         rxf_r     <= 1'b0;
         ovr_r     <= 1'b0;
      end else begin
         // every frame lands in background unless it is held
         // ready again right after the previous frame
         if (enable_r && RX_EVT.done && !(bg_full_r && !fg_free)) begin
            bg_r <= RX_EVT.data;
         end
         // background drained to foreground when freed with no accepted good frame arriving
         // rxf set only with an accepted good frame
         if (do_copy) begin
            fg_r  <= RX_EVT.data;
            rxf_r <= 1'b1;
         end else if (bg_pend) begin
            fg_r  <= bg_r;
            rxf_r <= 1'b1;
         end else if (rxf_clr) begin
            rxf_r <= 1'b0;
         end
         if (bg_pend) begin
            bg_full_r <= 1'b0;
         end else if (good_acc && !fg_free) begin
            bg_full_r <= 1'b1;
         end
         if (do_ovr) begin
            ovr_r <= 1'b1;
         end else if (wr_en && hit_rf && PSTRB[0] && PWDATA[BIT_OVR]) begin
            ovr_r <= 1'b0;
         end
      end
   end

   assign RX_IRQ  = rxf_r & rxie_r[BIT_RXF];
   assign ERR_IRQ = ovr_r & rxie_r[BIT_OVR];
   assign TX_IRQ  = |(txe_r & txie_r);

   // ---------------------------------------------------------------
   // transmit control
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tx_st_r <= TX_IDLE;
         cur_r   <= 2'd0;
      end else begin
         unique case (tx_st_r)
            TX_IDLE: begin
               if (enable_r && ARB_START && any_sched) begin
                  cur_r   <= best;
                  tx_st_r <= TX_BUSY;
               end
            end
            TX_BUSY: begin
               // carries on regardless of the rx fifo
               if (TX_DONE || TX_ERR || !enable_r) begin
                  tx_st_r <= TX_IDLE;
               end
            end
         endcase
      end
   end

   wire tx_ok = (tx_st_r == TX_BUSY) & TX_DONE;

   // one flag set per buffer, three by default
   genvar g;
   generate
      for (g = 0; g < NBUF; g++) begin : g_buf
         wire on_air   = (tx_st_r == TX_BUSY) && (cur_r == 2'(g));
         // abort only if not on the bus
         wire grant    = abort_request_bit_r[g] & ~txe_r[g] & ~on_air;
         wire sent     = tx_ok && (cur_r == 2'(g));
         // write one to tx empty position schedules the buffer
         wire sched    = wr_en & hit_tf & PSTRB[0] & PWDATA[g] & txe_r[g];
         wire ak_clr   = wr_en & hit_tf & PSTRB[0] & PWDATA[BIT_ABORT_ACK_FLAG+g];
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               txe_r[g]   <= RST_TXE[g];
               abort_request_bit_r[g] <= 1'b0;
               abort_ack_flag_r[g] <= 1'b0;
               local_priority_field_r[g]  <= RST_LOCAL_PRIORITY_FIELD;
            end else begin
               // success sets empty, ack stays zero
               if (sent || grant) begin
                  txe_r[g] <= 1'b1;
               end else if (sched) begin
                  txe_r[g] <= 1'b0;
               end
               if (grant) begin
                  abort_ack_flag_r[g] <= 1'b1;
               end else if (sent || sched || ak_clr) begin
                  abort_ack_flag_r[g] <= 1'b0;
               end
               if (sent || grant) begin
                  abort_request_bit_r[g] <= 1'b0;
               end else if (wr_en && hit_tc && PSTRB[0]) begin
                  abort_request_bit_r[g] <= PWDATA[g] & ~txe_r[g];
               end
               if (wr_en && hit_pr && pr_idx == 2'(g) && PSTRB[0]) begin
                  local_priority_field_r[g] <= PWDATA[7:0];
               end
            end
         end
         // 13 bytes per buffer, byte-enabled writes
         for (genvar b = 0; b < FRAME_BYTES; b++) begin : g_byte
            always_ff @(posedge CLK) begin
               if (wr_en && hit_tb && tb_idx == 2'(g) && tb_word == 4'(b / 4) &&
                   PSTRB[b % 4]) begin
                  txbuf_r[g][b] <= PWDATA[(b % 4)*8 +: 8];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         enable_r <= 1'b0;
         loop_r   <= 1'b0;
         rxie_r   <= 2'b00;
         txie_r   <= '0;
      end else begin
         if (wr_en && hit_opt && PSTRB[0]) begin
            enable_r <= PWDATA[BIT_ENABLE];
         end
         if (wr_en && hit_md && PSTRB[0]) begin
            loop_r <= PWDATA[BIT_LOOPBACK];
         end
         if (wr_en && hit_rm && PSTRB[0]) begin
            rxie_r <= PWDATA[1:0];
            txie_r <= PWDATA[4 +: NBUF];
         end
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // foreground seen as 13 bytes in four words
   logic [31:0] rd_mux;
   logic [127:0] fg_ext;
   always_comb begin
      fg_ext = {24'h0, fg_r[103:0]};
      rd_mux = 32'h0;
      if (hit_opt) rd_mux = {31'h0, enable_r};
      if (hit_md)  rd_mux = {31'h0, loop_r};
      if (hit_rf)  rd_mux = {30'h0, ovr_r, rxf_r};
      if (hit_rm)  rd_mux = {24'h0, 1'b0, txie_r, 2'b00, rxie_r};
      if (hit_tf)  rd_mux = {24'h0, 1'b0, abort_ack_flag_r, 1'b0, txe_r};
      if (hit_tc)  rd_mux = {29'h0, abort_request_bit_r};
      if (hit_pr)  rd_mux = {24'h0, local_priority_field_r[pr_idx]};
      if (hit_rb)  rd_mux = fg_ext[rb_word*32 +: 32];
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_r <= 32'h0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         rdata_r <= rd_mux;
      end
   end
   assign PRDATA = rd_en ? rdata_r : 32'h0;

endmodule

// file: test/msgbuf_mgr_properties.sv
// Purpose: port-level checks of the message buffer manager
// Assumes: zero-wait APB, single clock domain
// Notes:   tx irq causes are allowed one to three cycles, rx and error irq causes one cycle
`timescale 1ns/1ps
module msgbuf_chk
   import msgbuf_pkg::*;
(
   input logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
   input logic [11:0] PADDR,
   input logic [31:0] PWDATA, PRDATA,
   input logic [3:0]  PSTRB,
   input logic        CAN_RX, CAN_TX, ENG_TXD, ENG_RXD, ENG_ACK_REQ, ENG_ACK_EN,
   input rx_event_s   RX_EVT,
   input logic        ARB_START, TX_REQ, TX_DONE, TX_ERR,
   input frame_t      TX_FRAME,
   input logic        RX_IRQ, TX_IRQ, ERR_IRQ, ENABLED
);
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire apbw = PSEL & PENABLE & PWRITE;
   property p_off; !ENABLED |-> CAN_TX; endproperty
   a_off: assert property (p_off) else $error("tx pin not recessive when off");
   property p_req; $rose(TX_REQ) |-> $past(ARB_START) && $past(ENABLED); endproperty
   a_req: assert property (p_req) else $error("tx request without arbitration");
   property p_hold; TX_REQ && !TX_DONE && !TX_ERR |=> TX_REQ && $stable(TX_FRAME); endproperty
   a_hold: assert property (p_hold) else $error("frame on air dropped");
   property p_drop; TX_REQ && (TX_DONE || TX_ERR) |=> !TX_REQ; endproperty
   a_drop: assert property (p_drop) else $error("request kept after end");
   property p_err; PSLVERR |-> PSEL && PENABLE; endproperty
   a_err: assert property (p_err) else $error("slave error outside access");
   property p_rdz; !(PSEL && PENABLE && !PWRITE) |-> PRDATA == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside access");
   property p_rxi; $rose(RX_IRQ) |-> $past(RX_EVT.done) || $past(apbw); endproperty
   a_rxi: assert property (p_rxi) else $error("rx irq without cause");
   property p_eri; $rose(ERR_IRQ) |-> $past(RX_EVT.done) || $past(apbw); endproperty
   a_eri: assert property (p_eri) else $error("error irq without cause");
   property p_txi; $rose(TX_IRQ) |-> $past(apbw) || $past(TX_DONE) || $past(TX_DONE, 2) ||
      $past(apbw, 2) || $past(apbw, 3); endproperty
   a_txi: assert property (p_txi) else $error("tx irq without cause");
   property p_ack; ENG_ACK_EN |-> ENG_ACK_REQ; endproperty
   a_ack: assert property (p_ack) else $error("ack without request");
   c_done: cover property (TX_DONE);
   c_terr: cover property (TX_ERR);
   c_ovr: cover property (ERR_IRQ);
   c_slv: cover property (PSLVERR);
endmodule

bind msgbuf_mgr msgbuf_chk chk (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PSTRB(PSTRB), .CAN_RX(CAN_RX), .CAN_TX(CAN_TX), .ENG_TXD(ENG_TXD),
   .ENG_RXD(ENG_RXD), .ENG_ACK_REQ(ENG_ACK_REQ), .ENG_ACK_EN(ENG_ACK_EN), .RX_EVT(RX_EVT),
   .ARB_START(ARB_START), .TX_REQ(TX_REQ), .TX_DONE(TX_DONE), .TX_ERR(TX_ERR),
   .TX_FRAME(TX_FRAME), .RX_IRQ(RX_IRQ), .TX_IRQ(TX_IRQ), .ERR_IRQ(ERR_IRQ), .ENABLED(ENABLED));

// file: test/can_far_model.sv
// Purpose: far side: transceiver and engine timing of a frame on air
// Assumes: one frame on air at a time, fixed air time
// Notes:   other nodes stay recessive; an error ends the attempt
`timescale 1ns/1ps
module can_far_model #(
   parameter int AIR = 12
) (
   input  wire logic CLK,
   input  wire logic RESET_N,
   input  wire logic go,
   input  wire logic fail,
   input  wire logic TX_REQ,
   input  wire logic CAN_TX,
   output logic      ARB_START,
   output logic      TX_DONE,
   output logic      TX_ERR,
   output logic      CAN_RX
);
   int cnt;
   assign CAN_RX = CAN_TX;
   // air time, then success or error
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ARB_START <= 1'b0;
         TX_DONE   <= 1'b0;
         TX_ERR    <= 1'b0;
         cnt       <= 0;
      end else begin
         ARB_START <= go;
         TX_DONE   <= 1'b0;
         TX_ERR    <= 1'b0;
         if (TX_REQ && !TX_DONE && !TX_ERR) cnt <= cnt + 1;
         if (cnt == AIR) begin
            cnt     <= 0;
            TX_DONE <= !fail;
            TX_ERR  <= fail;
         end
      end
   end
endmodule

// file: test/msgbuf_mgr_tb.sv
// Purpose: self-checking bench of the message buffer manager
// Assumes: zero-wait APB slave, 40 MHz clock
// Notes:   word 0 of each tx buffer carries a per-buffer mark
`timescale 1ns/1ps
module msgbuf_mgr_tb;
   import msgbuf_pkg::*;
   logic        CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e, go, fail;
   logic        CAN_RX, CAN_TX, ENG_TXD, ENG_RXD, ENG_ACK_REQ, ENG_ACK_EN, ARB_START;
   logic        TX_REQ, TX_DONE, TX_ERR, RX_IRQ, TX_IRQ, ERR_IRQ, ENABLED;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, r, w;
   logic [3:0]  PSTRB;
   rx_event_s   RX_EVT;
   frame_t      TX_FRAME;
   int          miscompares, samples_checked, cyc;
   msgbuf_mgr uut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CAN_RX(CAN_RX), .CAN_TX(CAN_TX),
      .ENG_TXD(ENG_TXD), .ENG_RXD(ENG_RXD), .RX_EVT(RX_EVT), .ENG_ACK_REQ(ENG_ACK_REQ),
      .ENG_ACK_EN(ENG_ACK_EN), .ARB_START(ARB_START), .TX_REQ(TX_REQ),
      .TX_FRAME(TX_FRAME), .TX_DONE(TX_DONE), .TX_ERR(TX_ERR), .RX_IRQ(RX_IRQ),
      .TX_IRQ(TX_IRQ), .ERR_IRQ(ERR_IRQ), .ENABLED(ENABLED));
   can_far_model far (.CLK(CLK), .RESET_N(RESET_N), .go(go), .fail(fail), .TX_REQ(TX_REQ),
      .CAN_TX(CAN_TX), .ARB_START(ARB_START), .TX_DONE(TX_DONE), .TX_ERR(TX_ERR),
      .CAN_RX(CAN_RX));
   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic wrt, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wrt;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      r = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r & m, x);
   endtask
   // a zero mark means no request came up
   task automatic tx_start(output logic [31:0] f);
      f = 32'h0;
      @(posedge CLK);
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      for (int i = 0; i < 10 && f == 32'h0; i++) begin
         @(posedge CLK);
         if (TX_REQ === 1'b1) f = TX_FRAME[31:0];
      end
   endtask
   task automatic tx_end;
      for (int i = 0; i < 40 && TX_REQ !== 1'b0; i++) @(posedge CLK);
      repeat (3) @(posedge CLK);
   endtask
   task automatic rx(input logic [31:0] d, input logic [3:0] k);
      @(posedge CLK);
      RX_EVT <= {1'b1, k, frame_t'(d)};
      @(posedge CLK);
      RX_EVT.done <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   // -------------------------------------------------------------
   // clock, watchdog, sequence
   // -------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      logic [7:0] local_priority_field [3] = '{8'h20, 8'h10, 8'h10};
      int         ord [3] = '{1, 2, 0};
      {RESET_N, PSEL, PENABLE, PWRITE, go, fail} = 6'h0;
      {PADDR, PWDATA, RX_EVT} = '0;
      {ENG_TXD, ENG_ACK_REQ, PSTRB} = 6'h3f;
      repeat (8) @(posedge CLK);
      RESET_N <= 1'b1;
      rc(OFS_TXFLAG, 32'h77, {29'h0, RST_TXE});
      rc(OFS_OPTION, 32'h1, 32'h0);
      rc(12'h3fc, 32'hffffffff, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, OFS_OPTION, 32'h1);
      apb(1'b1, OFS_RXMASK, 32'h73);
      chk({31'h0, ENABLED}, 32'h1);
      ENG_TXD <= 1'b0;
      repeat (4) @(posedge CLK);
      chk({31'h0, CAN_TX}, 32'h0);
      chk({31'h0, ENG_RXD}, 32'h0);
      ENG_TXD <= 1'b1;
      repeat (4) @(posedge CLK);
      chk({31'h0, CAN_TX}, 32'h1);
      for (int n = 0; n < NUM_TXBUF; n++) begin
         for (int k = 0; k < 4; k++)
            apb(1'b1, 12'(OFS_TXBUF0 + OFS_TXSTEP * n + 4 * k), k ? 32'h0 : 32'h5a00 + n);
         apb(1'b1, 12'(OFS_TXPRIO0 + 4 * n), {24'h0, local_priority_field[n]});
      end
      apb(1'b1, OFS_TXFLAG, 32'h7);
      for (int n = 0; n < NUM_TXBUF; n++) begin
         tx_start(w);
         chk(w, 32'h5a00 + ord[n]);
         tx_end();
      end
      rc(OFS_TXFLAG, 32'h77, 32'h7);
      chk({31'h0, TX_IRQ}, 32'h1);
      apb(1'b1, OFS_TXFLAG, 32'h3);
      fail <= 1'b1;
      tx_start(w);
      chk(w, 32'h5a01);
      RX_EVT.own <= 1'b1;
      @(posedge CLK);
      chk({31'h0, ENG_ACK_EN}, 32'h0);
      RX_EVT.own <= 1'b0;
      tx_end();
      fail <= 1'b0;
      apb(1'b1, OFS_TXPRIO0, 32'h5);
      tx_start(w);
      chk(w, 32'h5a00);
      tx_end();
      chk({31'h0, ENG_ACK_EN}, 32'h1);
      apb(1'b1, OFS_TXFLAG, 32'h5);
      tx_start(w);
      apb(1'b1, OFS_TXCTRL, 32'h7);
      tx_end();
      chk(w, 32'h5a00);
      rc(OFS_TXFLAG, 32'h77, 32'h67);
      apb(1'b1, OFS_TXFLAG, 32'h60);
      rc(OFS_TXFLAG, 32'h77, 32'h7);
      rx(32'hc0de0001, 4'b1100);
      rc(OFS_RXFLAG, 32'h3, 32'h1);
      rc(OFS_RXBUF, 32'hffffffff, 32'hc0de0001);
      chk({31'h0, RX_IRQ}, 32'h1);
      rx(32'hc0de0002, 4'b1000);
      rc(OFS_RXBUF, 32'hffffffff, 32'hc0de0001);
      rx(32'hc0de0003, 4'b1100);
      rx(32'hc0de0004, 4'b1100);
      rc(OFS_RXFLAG, 32'h3, 32'h3);
      chk({31'h0, ERR_IRQ}, 32'h1);
      apb(1'b1, OFS_TXFLAG, 32'h4);
      tx_start(w);
      chk(w, 32'h5a02);
      tx_end();
      apb(1'b1, OFS_RXFLAG, 32'h3);
      rc(OFS_RXFLAG, 32'h3, 32'h1);
      rc(OFS_RXBUF, 32'hffffffff, 32'hc0de0003);
      apb(1'b1, OFS_RXFLAG, 32'h1);
      rc(OFS_RXFLAG, 32'h3, 32'h0);
      chk({31'h0, RX_IRQ}, 32'h0);
      rx(32'hc0de0005, 4'b1110);
      rc(OFS_RXFLAG, 32'h3, 32'h0);
      rx(32'hc0de0006, 4'b1111);
      rc(OFS_RXBUF, 32'hffffffff, 32'hc0de0006);
      apb(1'b1, OFS_RXFLAG, 32'h1);
      apb(1'b1, OFS_MODE, 32'h1);
      rx(32'hc0de0007, 4'b1110);
      rc(OFS_RXBUF, 32'hffffffff, 32'hc0de0007);
      rc(OFS_RXFLAG, 32'h3, 32'h1);
      apb(1'b1, OFS_RXFLAG, 32'h1);
      apb(1'b1, OFS_MODE, 32'h0);
      apb(1'b1, OFS_OPTION, 32'h0);
      apb(1'b1, OFS_TXFLAG, 32'h1);
      tx_start(w);
      chk(w, 32'h0);
      chk({30'h0, ENABLED, CAN_TX}, 32'h1);
      give_verdict();
   end
endmodule
